// [ptm_pkg.sv]
/*
 * constants for the period timer: register offsets, field positions, reset values.
 * assumes an APB slave with 32-bit data, one aligned word per register.
 */
package ptm_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_INTERRUPT_CONTROL = 8'h0B;
    localparam logic [7:0]  IDX_PERIPHERAL_FLAGS  = 8'h0C;
    localparam logic [7:0]  IDX_PERIOD_COUNTER    = 8'h11;
    localparam logic [7:0]  IDX_TIMER_CONTROL     = 8'h12;
    localparam logic [7:0]  IDX_PERIPH_IRQ_EN     = 8'h8C;
    localparam logic [7:0]  IDX_PERIOD_LIMIT      = 8'h92;
    localparam int          ADDR_W                = 10;
    // timer control fields
    localparam int          TC_POST_LSB           = 3;
    localparam int          TC_POST_MSB           = 6;
    localparam int          TC_EN_BIT             = 2;
    localparam int          TC_PRE_MSB            = 1;
    localparam logic [7:0]  TC_WMASK              = 8'h7F;
    // interrupt bits
    localparam int          FLAG_BIT              = 1;
    localparam int          GIE_BIT               = 7;
    localparam int          PERIPHERAL_IRQ_GATE_BIT              = 6;
    localparam logic [7:0]  FLAGS_WMASK           = 8'h5F;
    // reset values
    localparam logic [7:0]  RST_LIMIT             = 8'hFF;
    localparam logic [7:0]  RST_ZERO              = 8'h00;
    // prescale codes
    localparam logic [1:0]  PRE_DIV1              = 2'h0;
    localparam logic [1:0]  PRE_DIV4              = 2'h1;
    localparam logic [3:0]  PRE_MAX4              = 4'h3;
    localparam logic [3:0]  PRE_MAX16             = 4'hF;
endpackage : ptm_pkg

// [ptm_prescaler.sv]
/*
 * prescaler: divides the clock by one, four or sixteen into single-cycle ticks.
 * assumes the enable is synchronous to pclk.
 */
`timescale 1ns/1ns
module ptm_prescaler (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       enable,
    input  wire logic [1:0] sel,
    output logic            tick
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [3:0] top;
    logic       wrap;

    // codes above 01 all divide by sixteen
    assign top  = (sel == ptm_pkg::PRE_DIV4) ? ptm_pkg::PRE_MAX4 : ptm_pkg::PRE_MAX16;
    assign wrap = (sel == ptm_pkg::PRE_DIV1) || (cnt_q >= top);
    assign tick = enable && wrap;
    assign cnt_d = !enable ? cnt_q : (wrap ? 4'h0 : cnt_q + 4'h1);

    // the phase is kept while stopped so counting resumes where it left off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : ptm_prescaler

// [ptm_postscaler.sv]
/*
 * postscaler: passes every Nth match, N being the select value plus one.
 * assumes match is a single-cycle pulse.
 */
`timescale 1ns/1ns
module ptm_postscaler (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       match,
    input  wire logic [3:0] sel,
    output logic            fire
);
    logic [3:0] cnt_q;
    logic       last;

    // compare with >= so lowering the select mid-run cannot skip a wrap
    assign last = (cnt_q >= sel);
    assign fire = match && last;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
        end else if (match) begin
            cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
        end
    end
endmodule : ptm_postscaler

// [ptm_timer.sv]
/*
 * period timer top: APB register slave, 8-bit counter with period compare, prescaler,
 * postscaler and period-match interrupt.
 * assumes an APB master in the pclk domain; pins and serial port are synchronous.
 */
`timescale 1ns/1ns
module ptm_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             ssp_shift_tick,
    output logic             cycle_done,
    output logic             irq
);
    logic [7:0]  counter_q;
    logic [7:0]  counter_d;
    logic [7:0]  limit_q;
    logic [6:0]  control_q;
    logic [7:0]  flags_q;
    logic [7:0]  flags_d;
    logic [7:0]  irq_en_q;
    logic [7:0]  intctl_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        ssp_tick_q;
    logic        done_q;
    logic        irq_q;
    logic        tick;
    logic        match;
    logic        fire;
    logic        at_limit;
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic        word_ok;
    logic        hit_ic;
    logic        hit_fl;
    logic        hit_cn;
    logic        hit_tc;
    logic        hit_ie;
    logic        hit_pl;
    logic        mapped;
    logic [7:0]  rsel;
    logic        count_en;
    logic        pready_q;
    logic        setup_rd;
    logic [1:0]  pre_sel;
    logic [3:0]  post_sel;
    logic        mode4;
    logic        mode16;

    // the slave answers in the first access cycle, so pready is always high
    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // address decode: word index is paddr divided by four
    assign idx     = paddr[ptm_pkg::ADDR_W-1:2];
    assign word_ok = (paddr[1:0] == 2'b00) && (paddr[11:ptm_pkg::ADDR_W] == 2'b00);
    assign hit_ic  = word_ok && (idx == ptm_pkg::IDX_INTERRUPT_CONTROL);
    assign hit_fl  = word_ok && (idx == ptm_pkg::IDX_PERIPHERAL_FLAGS);
    assign hit_cn  = word_ok && (idx == ptm_pkg::IDX_PERIOD_COUNTER);
    assign hit_tc  = word_ok && (idx == ptm_pkg::IDX_TIMER_CONTROL);
    assign hit_ie  = word_ok && (idx == ptm_pkg::IDX_PERIPH_IRQ_EN);
    assign hit_pl  = word_ok && (idx == ptm_pkg::IDX_PERIOD_LIMIT);
    assign mapped  = hit_ic | hit_fl | hit_cn | hit_tc | hit_ie | hit_pl;
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;
    assign setup_rd = psel && !penable && !pwrite;

    // read mux; bit seven of control is unimplemented and reads zero
    assign rsel = hit_ic ? intctl_q :
                  hit_fl ? flags_q :
                  hit_cn ? counter_q :
                  hit_tc ? {1'b0, control_q} :
                  hit_ie ? irq_en_q :
                  hit_pl ? limit_q :
                  8'h00;

    // counting engine: prescaler tick advances counter, compare makes the match
    assign count_en = control_q[ptm_pkg::TC_EN_BIT];
    assign at_limit = (counter_q == limit_q);
    assign match    = tick && at_limit;
    assign counter_d = (wr && hit_cn) ? pwdata[7:0] :
                       !tick          ? counter_q :
                       at_limit       ? 8'h00 :
                       counter_q + 8'h01;

    ptm_prescaler u_pre (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (count_en),
        .sel     (control_q[ptm_pkg::TC_PRE_MSB:0]),
        .tick    (tick)
    );

    ptm_postscaler u_post (
        .pclk    (pclk),
        .presetn (presetn),
        .match   (match),
        .sel     (control_q[ptm_pkg::TC_POST_MSB:ptm_pkg::TC_POST_LSB]),
        .fire    (fire)
    );

    // flag register: software writes, but a postscaler event wins over a clear
    always_comb begin
        flags_d = flags_q;
        if (wr && hit_fl) begin
            flags_d = pwdata[7:0] & ptm_pkg::FLAGS_WMASK;
        end
        if (fire) begin
            flags_d[ptm_pkg::FLAG_BIT] = 1'b1;
        end
    end

    // timer state and limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_q <= ptm_pkg::RST_ZERO;
            limit_q   <= ptm_pkg::RST_LIMIT;
        end else begin
            counter_q <= counter_d;
            if (wr && hit_pl) begin
                limit_q <= pwdata[7:0];
            end
        end
    end

    // software-owned control registers, and the flag register, which the postscaler also sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= 7'h00;
            irq_en_q  <= ptm_pkg::RST_ZERO;
            intctl_q  <= ptm_pkg::RST_ZERO;
            flags_q   <= ptm_pkg::RST_ZERO;
        end else begin
            flags_q <= flags_d;
            if (wr && hit_tc) begin
                control_q <= pwdata[6:0];
            end
            if (wr && hit_ie) begin
                irq_en_q <= pwdata[7:0] & ptm_pkg::FLAGS_WMASK;
            end
            if (wr && hit_ic) begin
                intctl_q <= pwdata[7:0];
            end
        end
    end

    // ready held high from reset on, so every transfer ends after one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b1;
        end else begin
            pready_q <= 1'b1;
        end
    end

    // bus answer registers, loaded in the setup cycle so they stand during the access phase,
    // the one edge at which the master takes them; a counter read is one cycle old as a result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= setup_rd ? {24'h00_0000, rsel} : 32'h0000_0000;
            pslverr_q <= psel && !penable && !mapped;
        end
    end

    // outputs from flops: match to serial port, cycle-done on flag rise, interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ssp_tick_q <= 1'b0;
            done_q     <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            ssp_tick_q <= match;
            done_q     <= flags_d[ptm_pkg::FLAG_BIT] && !flags_q[ptm_pkg::FLAG_BIT];
            irq_q      <= intctl_q[ptm_pkg::GIE_BIT] && intctl_q[ptm_pkg::PERIPHERAL_IRQ_GATE_BIT]
                          && |(flags_d & irq_en_q);
        end
    end

    assign ssp_shift_tick = ssp_tick_q;
    assign cycle_done     = done_q;
    assign irq            = irq_q;

    // checks; the mode flags below only serve the cadence properties
    assign pre_sel  = control_q[ptm_pkg::TC_PRE_MSB:0];
    assign post_sel = control_q[ptm_pkg::TC_POST_MSB:ptm_pkg::TC_POST_LSB];
    assign mode4    = count_en && (pre_sel == ptm_pkg::PRE_DIV4);
    assign mode16   = count_en && (pre_sel != ptm_pkg::PRE_DIV1) && (pre_sel != ptm_pkg::PRE_DIV4);

    // divide by four: a tick, three quiet cycles, then the next tick
    sequence seq_div4_start;
        tick && mode4;
    endsequence

    sequence seq_div4_hold;
        mode4 [*3];
    endsequence

    // divide by sixteen: fifteen quiet cycles, split so no repetition count exceeds eight
    sequence seq_div16_start;
        tick && mode16;
    endsequence

    sequence seq_div16_hold;
        mode16 [*8] ##1 mode16 [*7];
    endsequence

    // counting and wrap
    AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        match && !(wr && hit_cn) |=> counter_q == 8'h00)
        else $error("counter did not wrap after match");

    AST_WRAP_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        tick && !at_limit && !(wr && hit_cn) |=> counter_q == $past(counter_q) + 8'h01)
        else $error("counter did not advance on a tick");

    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !count_en && !(wr && hit_cn) |=> $stable(counter_q))
        else $error("counter moved while disabled");

    AST_NOMATCH: assert property (@(posedge pclk) disable iff (!presetn)
        !count_en |-> !match)
        else $error("match while disabled");

    AST_TICK_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !count_en |-> !tick)
        else $error("prescaler ticked while disabled");

    AST_SSP: assert property (@(posedge pclk) disable iff (!presetn)
        match |=> ssp_shift_tick)
        else $error("serial tick missing");

    AST_SSP_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        ssp_shift_tick |-> $past(match))
        else $error("serial tick without a match");

    // prescaler cadence
    AST_DIV1: assert property (@(posedge pclk) disable iff (!presetn)
        count_en && control_q[1:0] == 2'b00 |-> tick)
        else $error("divide by one missed a tick");

    AST_DIV4_GAP: assert property (@(posedge pclk) disable iff (!presetn)
        seq_div4_start |=> (!tick || !mode4) [*3])
        else $error("divide by four ticked early");

    AST_DIV4_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
        seq_div4_start ##1 seq_div4_hold ##1 mode4 |-> tick)
        else $error("divide by four missed a tick");

    AST_DIV16_GAP: assert property (@(posedge pclk) disable iff (!presetn)
        seq_div16_start |=> (!tick || !mode16) [*8])
        else $error("divide by sixteen ticked early");

    AST_DIV16_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
        seq_div16_start ##1 seq_div16_hold ##1 mode16 |-> tick)
        else $error("divide by sixteen missed a tick");

    // postscaler, flag and interrupt
    AST_FIRE_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        fire |-> match)
        else $error("postscaler fired without a match");

    AST_POST_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        match && (post_sel == 4'h0) |-> fire)
        else $error("postscale one did not pass a match");

    AST_FLAGSET: assert property (@(posedge pclk) disable iff (!presetn)
        fire |=> flags_q[1])
        else $error("flag not set by postscaler");

    AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_fl && !fire && !pwdata[ptm_pkg::FLAG_BIT] |=> !flags_q[ptm_pkg::FLAG_BIT])
        else $error("flag not cleared by a zero write");

    AST_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flags_q[1]) |-> cycle_done)
        else $error("cycle done missing on flag rise");

    AST_DONE_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        cycle_done |-> $rose(flags_q[ptm_pkg::FLAG_BIT]))
        else $error("cycle done without a flag rise");

    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> $past(intctl_q[7]) && $past(intctl_q[6]))
        else $error("irq without gates");

    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        intctl_q[ptm_pkg::GIE_BIT] && intctl_q[ptm_pkg::PERIPHERAL_IRQ_GATE_BIT] && (|(flags_d & irq_en_q)) |=> irq)
        else $error("irq missing with gates open");

    AST_IRQ_MASK: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> |(flags_q & $past(irq_en_q)))
        else $error("irq without an enabled flag");

    // register bus
    AST_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_pl |=> limit_q == $past(pwdata[7:0]))
        else $error("limit write lost");

    AST_RDATA: assert property (@(posedge pclk) disable iff (!presetn)
        setup_rd && hit_pl |=> prdata == {24'h00_0000, $past(limit_q)})
        else $error("limit read data wrong in access phase");

    AST_CTRL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        wr && hit_tc |=> control_q == $past(pwdata[6:0]))
        else $error("control write lost");

    AST_BIT7: assert property (@(posedge pclk) disable iff (!presetn)
        setup_rd && hit_tc |=> prdata[7] == 1'b0)
        else $error("control bit seven nonzero");

    AST_PSLVERR: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !mapped |=> pslverr)
        else $error("no error for unmapped access");
endmodule : ptm_timer

// [ptm_far_model.sv]
/*
 * far-side model: serial port taking the shift tick, pulse-width unit start-up.
 * assumes single-cycle pulses in the pclk domain.
 */
`timescale 1ns/1ns
module ptm_far_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ssp_shift_tick,
    input  wire logic        cycle_done,
    output logic [15:0]      tick_cnt_q,
    output logic [15:0]      gap_q,
    output logic [15:0]      done_cnt_q,
    output logic             pins_oe_n_q
);
    logic [15:0] since_q;

    // shift clock user: counts pulses and their spacing in cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 16'h0000;
            gap_q      <= 16'h0000;
            since_q    <= 16'h0001;
        end else if (ssp_shift_tick) begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            gap_q      <= since_q;
            since_q    <= 16'h0001;
        end else begin
            since_q    <= since_q + 16'h0001;
        end
    end

    // pins stay inputs until the first full cycle, so the power stage is never driven early
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_cnt_q  <= 16'h0000;
            pins_oe_n_q <= 1'h1;
        end else if (cycle_done) begin
            done_cnt_q  <= done_cnt_q + 16'h0001;
            pins_oe_n_q <= 1'h0;
        end
    end
endmodule : ptm_far_model

// [tb_top.sv]
/*
 * testbench for the period timer: apb master tasks and hand-written scenarios.
 * assumes the design files and the far-side model are compiled first.
 */
`timescale 1ns/1ns
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
    logic        ssp_shift_tick, cycle_done, irq, pins_oe_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [15:0] tick_cnt, gap, done_cnt;
    int          failures, n_compared;

    ptm_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ssp_shift_tick(ssp_shift_tick), .cycle_done(cycle_done), .irq(irq));
    ptm_far_model far_u (.pclk(pclk), .presetn(presetn), .ssp_shift_tick(ssp_shift_tick),
        .cycle_done(cycle_done), .tick_cnt_q(tick_cnt), .gap_q(gap), .done_cnt_q(done_cnt),
        .pins_oe_n_q(pins_oe_n));

    // 100 MHz clock
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one transfer; read data and error are taken at the edge where pready is seen high,
    // then one idle cycle so a following call never re-drives psel in the same time step
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        err_v = pslverr;
        rd_v  = prdata;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb

    task automatic do_reset();
        presetn <= 1'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
    endtask : do_reset

    // bounded wait for k more shift ticks
    task automatic wait_ticks(input int k);
        int n;
        logic [15:0] t0;
        n = 0;
        t0 = tick_cnt;
        while (int'(tick_cnt - t0) < k && n < 3000) begin
            n++;
            @(posedge pclk);
        end
        chk("tick wait", 32'h0000_0000, {31'h0, n == 3000});
    endtask : wait_ticks

    task automatic s_reset_values();
        logic [7:0] ix[5];
        ix = '{ptm_pkg::IDX_PERIOD_LIMIT, ptm_pkg::IDX_TIMER_CONTROL, ptm_pkg::IDX_PERIPHERAL_FLAGS,
               ptm_pkg::IDX_PERIPH_IRQ_EN, ptm_pkg::IDX_INTERRUPT_CONTROL};
        foreach (ix[i]) begin
            apb(1'h0, ix[i], 32'h0000_0000);
            chk("reset value", (i == 0) ? 32'h0000_00FF : 32'h0000_0000, rd_v);
        end
    endtask : s_reset_values

    task automatic s_regs();
        apb(1'h1, ptm_pkg::IDX_PERIOD_LIMIT, 32'h0000_005A);
        apb(1'h0, ptm_pkg::IDX_PERIOD_LIMIT, 32'h0000_0000);
        chk("limit", 32'h0000_005A, rd_v);
        apb(1'h1, ptm_pkg::IDX_TIMER_CONTROL, 32'h0000_00FB);
        apb(1'h0, ptm_pkg::IDX_TIMER_CONTROL, 32'h0000_0000);
        chk("control", 32'h0000_007B, rd_v);
        apb(1'h0, 8'h20, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0, err_v});
        chk("unmapped data", 32'h0000_0000, rd_v);
    endtask : s_regs

    // limit 3, every prescale code, then stop and hold
    task automatic s_count();
        logic [31:0] held;
        logic [15:0] t1;
        apb(1'h1, ptm_pkg::IDX_PERIOD_LIMIT, 32'h0000_0003);
        for (int p = 0; p < 4; p++) begin
            apb(1'h1, ptm_pkg::IDX_TIMER_CONTROL, 32'h0000_0004 | p);
            wait_ticks(3);
            chk("match spacing", (p == 0) ? 32'h4 : (p == 1) ? 32'h10 : 32'h40, {16'h0, gap});
        end
        apb(1'h1, ptm_pkg::IDX_TIMER_CONTROL, 32'h0000_0000);
        apb(1'h0, ptm_pkg::IDX_PERIOD_COUNTER, 32'h0000_0000);
        held = rd_v;
        // taken only now, so a tick launched by the last enabled match is already counted
        t1 = tick_cnt;
        repeat (40) @(posedge pclk);
        apb(1'h0, ptm_pkg::IDX_PERIOD_COUNTER, 32'h0000_0000);
        chk("held count", held, rd_v);
        chk("ticks while stopped", {16'h0, t1}, {16'h0, tick_cnt});
    endtask : s_count

    // postscale 3 from a fresh reset: flag after the third match
    task automatic s_post();
        int n;
        do_reset();
        apb(1'h1, ptm_pkg::IDX_PERIOD_LIMIT, 32'h0000_0003);
        apb(1'h1, ptm_pkg::IDX_TIMER_CONTROL, 32'h0000_0010);
        apb(1'h1, ptm_pkg::IDX_TIMER_CONTROL, 32'h0000_0014);
        n = 0;
        while (done_cnt === 16'h0000 && n < 500) begin
            n++;
            @(posedge pclk);
        end
        chk("matches per flag", 32'h0000_0003, {16'h0, tick_cnt});
        chk("masked irq", 32'h0000_0000, {31'h0, irq});
        repeat (40) @(posedge pclk);
        chk("one done pulse", 32'h0000_0001, {16'h0, done_cnt});
        chk("pins driven", 32'h0000_0000, {31'h0, pins_oe_n});
        apb(1'h0, ptm_pkg::IDX_PERIPHERAL_FLAGS, 32'h0000_0000);
        chk("flag bit", 32'h0000_0002, rd_v);
        apb(1'h1, ptm_pkg::IDX_PERIPH_IRQ_EN, 32'h0000_0002);
        apb(1'h1, ptm_pkg::IDX_INTERRUPT_CONTROL, 32'h0000_00C0);
        // irq is registered from the gates, so it shows one edge after the write has landed
        @(posedge pclk);
        chk("irq raised", 32'h0000_0001, {31'h0, irq});
        apb(1'h1, ptm_pkg::IDX_TIMER_CONTROL, 32'h0000_0000);
        apb(1'h1, ptm_pkg::IDX_PERIPHERAL_FLAGS, 32'h0000_0000);
        apb(1'h0, ptm_pkg::IDX_PERIPHERAL_FLAGS, 32'h0000_0000);
        chk("flag cleared", 32'h0000_0000, rd_v);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    endtask : s_post

    task automatic wrap_up();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // main sequence
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        failures = 0;
        n_compared = 0;
        do_reset();
        s_reset_values();
        s_regs();
        s_count();
        s_post();
        wrap_up();
    end

    // watchdog, well beyond the several hundred cycles the scenarios need
    initial begin
        #300000;
        failures++;
        wrap_up();
    end
endmodule : tb_top
